// File: bench/bcgc_core_sva.sv
// Port checker for the block check core, bound to every core instance.
`timescale 1ns/1ps

module bcgc_core_sva (
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       transceiver_select_n,
	input wire logic       checker_select_n,
	input wire logic       read_write,
	input wire logic [1:0] addr,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic       data_oe,
	input wire logic       irq_n_out,
	input wire logic       irq_n_oe
);
	// ****************************************************************
	// Shadow of the mode and parity interrupt enable
	// ****************************************************************
	logic [7:0] mode_q;
	logic       pirq;
	wire logic  cw     = !checker_select_n && transceiver_select_n && !read_write;
	wire logic  chk_rd = !checker_select_n && transceiver_select_n && read_write;
	wire logic  idle   = checker_select_n && transceiver_select_n;
	wire logic  ld     = (cw || (!transceiver_select_n && checker_select_n && read_write == mode_q[2]))
		&& addr == bcgc_pkg::ADDR_CHAR;
	wire logic  perr   = (mode_q[4] || &mode_q[1:0]) && data_in[7] != (mode_q[5] ? ^data_in[6:0] : ~^data_in[6:0]);

	// Follows mode and command writes; a master reset command clears both.
	always_ff @(posedge clk) begin
		if (srst || (cw && addr == bcgc_pkg::ADDR_CMD && data_in[1:0] == bcgc_pkg::CMD_MRESET)) begin
			mode_q <= 8'h00;
			pirq   <= 1'b0;
		end else begin
			if (cw && addr == bcgc_pkg::ADDR_MODE) mode_q <= data_in;
			if (cw && addr == bcgc_pkg::ADDR_CMD) pirq <= data_in[5];
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_stat_rd;
		chk_rd && addr == bcgc_pkg::ADDR_STATUS;
	endsequence
	sequence s_quiet2;
		idle [*2];
	endsequence

	a_read_drives_bus: assert property (chk_rd |=> data_oe)
		else $error("checker read not answered on the bus");
	a_bus_released: assert property (!chk_rd |=> !data_oe)
		else $error("bus driven without a checker read");
	a_reset_quiet: assert property ($fell(srst) |-> !data_oe && !irq_n_oe)
		else $error("outputs active just after reset");
	a_irq_pin_low: assert property (irq_n_oe |-> !irq_n_out)
		else $error("interrupt pin enabled without pulling low");
	a_status_clears: assert property (s_stat_rd ##1 idle |=> !irq_n_oe)
		else $error("interrupt still active after status read");
	a_parity_irq: assert property (ld && perr && pirq |-> ##2 irq_n_oe)
		else $error("parity error did not raise the interrupt");
	a_irq_holds: assert property (s_quiet2 |=> $stable(irq_n_oe))
		else $error("interrupt changed while the bus was idle");
	a_data_holds: assert property (idle |=> $stable(data_out))
		else $error("read data changed while the bus was idle");
endmodule : bcgc_core_sva

bind bcgc_core bcgc_core_sva chk_u (.clk(clk), .srst(srst), .transceiver_select_n(transceiver_select_n),
	.checker_select_n(checker_select_n), .read_write(read_write), .addr(addr), .data_in(data_in),
	.data_out(data_out), .data_oe(data_oe), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

// File: bench/bcgc_host_model.sv
// Host processor model that makes one-cycle strobed accesses on the parallel bus.
`timescale 1ns/1ps

module bcgc_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] data_out,
	output logic            transceiver_select_n,
	output logic            checker_select_n,
	output logic            read_write,
	output logic      [1:0] addr,
	output logic      [7:0] data_in
);
	// The bus starts released with both selects inactive.
	initial begin
		transceiver_select_n = 1'b1;
		checker_select_n     = 1'b1;
		read_write           = 1'b1;
		addr                 = 2'h0;
		data_in              = 8'h00;
	end

	// Drives after a falling edge, holds over the taking rising edge, then releases.
	task automatic xfer(input logic via_chk, input logic rw, input logic [1:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge clk);
		transceiver_select_n = via_chk;
		checker_select_n = !via_chk;
		read_write = rw;
		addr = a;
		data_in = d;
		@(posedge clk);
		@(negedge clk);
		q = data_out;
		transceiver_select_n = 1'b1;
		checker_select_n = 1'b1;
		data_in = ~d; // A released bus must not keep showing the last value.
	endtask : xfer
endmodule : bcgc_host_model

// File: bench/tb.sv
// Self-checking testbench of the block check core.
`timescale 1ns/1ps

module tb;
	logic       clk;
	logic       srst;
	logic       transceiver_select_n;
	logic       checker_select_n;
	logic       read_write;
	logic [1:0] addr;
	logic [7:0] data_in;
	logic [7:0] data_out;
	logic [7:0] q;
	logic [7:0] d;
	logic [6:0] acc;
	logic       irq_oe;
	int         errors;
	int         checks_done;
	int         seed;

	bcgc_core dut_u (.clk(clk), .srst(srst), .transceiver_select_n(transceiver_select_n),
		.checker_select_n(checker_select_n), .read_write(read_write), .addr(addr), .data_in(data_in),
		.data_out(data_out), .data_oe(), .irq_n_out(), .irq_n_oe(irq_oe));
	bcgc_host_model host_u (.clk(clk), .data_out(data_out), .transceiver_select_n(transceiver_select_n),
		.checker_select_n(checker_select_n), .read_write(read_write), .addr(addr), .data_in(data_in));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	function automatic logic par(input logic [6:0] x, input logic s);
		return s ? ^x : ~^x;
	endfunction : par

	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		host_u.xfer(1'b1, 1'b0, a, v, q);
	endtask : wr

	task automatic rd(input logic [1:0] a);
		host_u.xfer(1'b1, 1'b1, a, 8'h00, q);
	endtask : rd

	task automatic conclude;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : conclude

	// ****************************************************************
	// Clock, watchdog and scenarios
	// ****************************************************************
	// Free-running 10 MHz clock.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		conclude();
	end

	// Main sequence: reset, programming, transmit, refused, receive and direct loads.
	initial begin
		seed = 32'hF822;
		errors = 0;
		checks_done = 0;
		srst = 1'b1;
		repeat (8) @(posedge clk);
		@(negedge clk);
		srst = 1'b0;
		rd(bcgc_pkg::ADDR_MODE + 2'h1);
		check("mode after reset", q, 8'h00);
		wr(bcgc_pkg::ADDR_CMD, 8'h08);
		wr(bcgc_pkg::ADDR_CLASS, 8'h04);
		for (int s = 0; s < 2; s++) begin
			wr(bcgc_pkg::ADDR_MODE, {2'h2, s[0], 5'h1F});
			rd(bcgc_pkg::ADDR_MODE + 2'h1);
			check("mode", q, {2'h2, s[0], 5'h1F});
			wr(bcgc_pkg::ADDR_CMD, 8'h22);
			acc = 7'h00;
			for (int i = 0; i < 12; i++) begin
				d = (i == 3) ? 8'h84 : 8'($random(seed));
				host_u.xfer(1'b0, 1'b1, bcgc_pkg::ADDR_CHAR, d, q);
				acc = acc ^ d[6:0];
				rd(bcgc_pkg::ADDR_CHAR);
				check("char", q, {par(d[6:0], s[0]), d[6:0]});
				rd(bcgc_pkg::ADDR_CHECK);
				check("lrc", q, {par(acc, s[0]), acc});
				rd(bcgc_pkg::ADDR_STATUS);
				check("status", q, {5'h04, d[6:0] == 7'h04, d[7] != par(d[6:0], s[0]), 1'b0});
				rd(bcgc_pkg::ADDR_STATUS);
				check("status cleared", q, 8'h20);
			end
		end
		host_u.xfer(1'b0, 1'b0, bcgc_pkg::ADDR_CHAR, 8'h55, q);
		rd(bcgc_pkg::ADDR_CHAR);
		check("refused load", q, {par(d[6:0], 1'b1), d[6:0]});
		wr(bcgc_pkg::ADDR_MODE, 8'hBB);
		wr(bcgc_pkg::ADDR_CMD, 8'h22);
		host_u.xfer(1'b0, 1'b1, bcgc_pkg::ADDR_CHAR, 8'h41, q);
		host_u.xfer(1'b0, 1'b0, bcgc_pkg::ADDR_CHAR, 8'h41, q);
		rd(bcgc_pkg::ADDR_STATUS);
		check("receive error", q, 8'h21);
		host_u.xfer(1'b0, 1'b0, bcgc_pkg::ADDR_CHAR, 8'h41, q);
		rd(bcgc_pkg::ADDR_STATUS);
		check("receive zero", q, 8'h20);
		wr(bcgc_pkg::ADDR_MODE, 8'hB3);
		wr(bcgc_pkg::ADDR_CHAR, 8'h83);
		rd(bcgc_pkg::ADDR_CHAR);
		check("direct parity", q, 8'h03);
		check("parity irq", {7'h00, irq_oe}, 8'h01);
		rd(bcgc_pkg::ADDR_STATUS);
		check("direct status", q, 8'h22);
		rd(bcgc_pkg::ADDR_CHECK);
		check("direct no accumulate", q, 8'h00);
		check("irq released", {7'h00, irq_oe}, 8'h00);
		wr(bcgc_pkg::ADDR_MODE, 8'hBB);
		wr(bcgc_pkg::ADDR_CHAR, 8'h03);
		rd(bcgc_pkg::ADDR_CHECK);
		check("direct accumulate", q, 8'h03);
		// Bisync receive: sync class, escape pair, terminator with tail, restart, then transparent.
		wr(bcgc_pkg::ADDR_MODE, 8'h00);
		wr(bcgc_pkg::ADDR_CLASS, 8'h0C);
		wr(bcgc_pkg::ADDR_CLASS, 8'h08);
		wr(bcgc_pkg::ADDR_CLASS, 8'h04);
		wr(bcgc_pkg::ADDR_CLASS, 8'h14);
		wr(bcgc_pkg::ADDR_MODE, 8'h3B);
		wr(bcgc_pkg::ADDR_CMD, 8'h02);
		wr(bcgc_pkg::ADDR_CHAR, 8'h41);
		wr(bcgc_pkg::ADDR_CHAR, 8'h14);
		wr(bcgc_pkg::ADDR_CHAR, 8'h90);
		wr(bcgc_pkg::ADDR_CHAR, 8'h88);
		rd(bcgc_pkg::ADDR_CHECK);
		check("sync excluded", q, 8'h59);
		rd(bcgc_pkg::ADDR_STATUS);
		check("escape pair", q, 8'h08);
		wr(bcgc_pkg::ADDR_CHAR, 8'h84);
		wr(bcgc_pkg::ADDR_CHAR, 8'h5C);
		rd(bcgc_pkg::ADDR_STATUS);
		check("block end", q, 8'h05);
		wr(bcgc_pkg::ADDR_CHAR, 8'h41);
		rd(bcgc_pkg::ADDR_CHECK);
		check("stopped", q, 8'h81);
		wr(bcgc_pkg::ADDR_CMD, 8'h01);
		wr(bcgc_pkg::ADDR_CHAR, 8'h41);
		rd(bcgc_pkg::ADDR_CHECK);
		check("restarted", q, 8'hC0);
		wr(bcgc_pkg::ADDR_MODE, 8'h7B);
		wr(bcgc_pkg::ADDR_CHAR, 8'h84);
		rd(bcgc_pkg::ADDR_STATUS);
		check("bare terminator", q, 8'h00);
		wr(bcgc_pkg::ADDR_CHAR, 8'h90);
		wr(bcgc_pkg::ADDR_CHAR, 8'h84);
		rd(bcgc_pkg::ADDR_STATUS);
		check("escaped terminator", q, 8'h04);
		conclude();
	end
endmodule : tb

// File: inc/bcgc_pkg.sv
// Package of constants, modes and carriers for the block check generator and checker.
package bcgc_pkg;

	// ****************************************************************
	// Register addresses and command codes
	// ****************************************************************
	localparam logic [1:0] ADDR_CHAR    = 2'h0;
	localparam logic [1:0] ADDR_MODE    = 2'h1;
	localparam logic [1:0] ADDR_CMD     = 2'h2;
	localparam logic [1:0] ADDR_CHECK   = 2'h3;
	localparam logic [1:0] ADDR_CLASS   = 2'h2;
	localparam logic [1:0] ADDR_STATUS  = 2'h1;
	localparam logic [1:0] CMD_NOP      = 2'h0;
	localparam logic [1:0] CMD_START    = 2'h1;
	localparam logic [1:0] CMD_CLEAR    = 2'h2;
	localparam logic [1:0] CMD_MRESET   = 2'h3;

	// ****************************************************************
	// Field positions, reset values and codes
	// ****************************************************************
	localparam int         MODE_DIR_BIT  = 2;
	localparam int         MODE_DLA_BIT  = 3;
	localparam int         MODE_PEN_BIT  = 4;
	localparam int         MODE_PSN_BIT  = 5;
	localparam logic [7:0] MODE_RESET    = 8'h00;
	localparam logic [7:0] CMD_RESET     = 8'h00;
	localparam logic [1:0] POLY_NONE     = 2'h0;
	localparam logic [1:0] POLY_CRC16    = 2'h1;
	localparam logic [1:0] POLY_CRC12    = 2'h2;
	localparam logic [1:0] POLY_LRC8     = 2'h3;
	localparam logic [1:0] CLASS_NORMAL  = 2'h0;
	localparam logic [1:0] CLASS_SYNC    = 2'h1;
	localparam logic [1:0] CLASS_TERM    = 2'h2;
	localparam logic [1:0] CLASS_SECOND  = 2'h3;
	localparam logic [1:0] ACC_NORMAL    = 2'h0;
	localparam logic [1:0] ACC_TRANSP    = 2'h1;
	localparam logic [1:0] ACC_AUTO      = 2'h2;
	localparam logic [1:0] ACC_SINGLE    = 2'h3;
	localparam logic [7:0] ESC_CRC12     = 8'h1F;
	localparam logic [7:0] ESC_ASCII     = 8'h10;
	localparam logic [7:0] ESC_EBCDIC    = 8'h90;
	localparam logic [15:0] CRC16_POLY   = 16'h8005;
	localparam logic [11:0] CRC12_POLY   = 12'h80F;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {
		BCGC_RUN  = 3'b001,
		BCGC_TAIL = 3'b010,
		BCGC_STOP = 3'b100
	} bcgc_acc_state_t;

	typedef struct packed {
		logic check_error;
		logic parity_error;
		logic terminator;
		logic escape_pair;
	} bcgc_flags_t;

endpackage : bcgc_pkg

// File: src/bcgc_core.sv
// Block check generator and checker with character register, class array and status flags.
//
// Operation
// - Receive accumulates received check characters; error-free leaves zero remainder.
// - CRC-12 escape compare uses low six bits against 1F hex.
// - CRC-12 class lookup forces bit 6 to zero; host writes bit 6 clear.
// - CRC-16/LRC-8 escape compare uses eight bits, parity as MSB, 10 or 90 hex.
// - Class lookup ignores MSB; parity error flag still set on mismatch.
// - LRC-8 XORs low seven bits upward; MSB is odd/even parity over them.
// - LRC-8 uses only the upper check register; lower holds its value.
// - Parity enabled: generate parity on low seven bits, write into MSB.
// - Parity mismatch sets parity error flag; interrupt when its enable set.
// - Normal class characters accumulate in every accumulation mode, except a leading escape in transparent.
// - Class codes normal, sync, terminator, second; single and automatic accumulate all.
// - Sync excluded in normal bisync; transparent excludes each leading escape and any sync after an escape.
// - Transparent mode recognises terminator only after odd number of escapes.
// - Bisync terminator stops accumulation: receive after one/two more, transmit immediately.
// - Accumulated terminators set terminator flag, except unescaped ones in transparent and those in the tail.
// - Restart after false terminator by rewriting bisync mode or start command.
// - Outside transparent, escaped second-class character sets escape pair flag.
// - Polynomial field clears to zero on reset, enabling class array programming.
// - Transmit: generate, never flag check error; load on read/write high.
// - Receive: accumulate and flag check error; load on read/write low.
// - Direct load with enable clear: parity only, no accumulation or compare.
// - Direct load with enable set: accumulate and compare as selected.
// - Status read clears the four flags and releases the interrupt.
// - Parity sense one gives even total ones, zero gives odd.
`timescale 1ns/1ps

module bcgc_core (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       transceiver_select_n,
	input  wire logic       checker_select_n,
	input  wire logic       read_write,
	input  wire logic [1:0] addr,
	input  wire logic [7:0] data_in,
	output logic      [7:0] data_out,
	output logic            data_oe,
	output logic            irq_n_out,
	output logic            irq_n_oe
);

	// ****************************************************************
	// Storage
	// ****************************************************************
	logic [7:0]             char_reg;
	logic [7:0]             operating_mode;
	logic [7:0]             command;
	logic [7:0]             check_hi;
	logic [7:0]             check_lo;
	logic                   check_ptr;
	logic [1:0]             class_array [0:127];
	bcgc_pkg::bcgc_flags_t  flags;
	bcgc_pkg::bcgc_acc_state_t acc_state;
	logic [1:0]             tail_cnt;
	logic                   esc_odd;
	logic                   single_arm;

	// Decoded mode fields.
	logic [1:0] poly;
	logic [1:0] acc_mode;
	logic       dir_tx;
	logic       par_en;
	logic       par_even;
	assign poly     = operating_mode[1:0];
	assign dir_tx   = operating_mode[bcgc_pkg::MODE_DIR_BIT];
	assign par_en   = operating_mode[bcgc_pkg::MODE_PEN_BIT] | (poly == bcgc_pkg::POLY_LRC8);
	assign par_even = operating_mode[bcgc_pkg::MODE_PSN_BIT];
	assign acc_mode = operating_mode[7:6];

	// Parity bit for the low seven bits with the selected sense.
	function automatic logic bcgc_parity(input logic [6:0] d, input logic even);
		bcgc_parity = (^d) ^ ~even;
	endfunction : bcgc_parity

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	logic xcvr_load;
	logic chk_wr;
	logic chk_rd;
	logic load;
	logic direct;
	assign xcvr_load = !transceiver_select_n && checker_select_n && addr == bcgc_pkg::ADDR_CHAR
	                   && (read_write == dir_tx);
	assign chk_wr    = transceiver_select_n && !checker_select_n && !read_write;
	assign chk_rd    = transceiver_select_n && !checker_select_n && read_write;
	assign direct    = chk_wr && addr == bcgc_pkg::ADDR_CHAR;
	assign load      = xcvr_load || direct;

	// Character handling on a load.
	logic [7:0] par_char;
	logic       par_bit;
	logic       par_bad;
	logic [6:0] lookup_idx;
	logic [1:0] cls;
	logic       is_esc;
	logic       use_cmp;
	assign par_bit    = bcgc_parity(data_in[6:0], par_even);
	assign par_char   = par_en ? {par_bit, data_in[6:0]} : data_in;
	assign par_bad    = par_en && (par_bit != data_in[7]);
	assign lookup_idx = (poly == bcgc_pkg::POLY_CRC12) ? {1'b0, data_in[5:0]} : data_in[6:0];
	assign cls        = class_array[lookup_idx];
	assign is_esc     = (poly == bcgc_pkg::POLY_CRC12) ? (data_in[5:0] == bcgc_pkg::ESC_CRC12[5:0])
	                  : (par_char == bcgc_pkg::ESC_ASCII || par_char == bcgc_pkg::ESC_EBCDIC);
	assign use_cmp    = xcvr_load || operating_mode[bcgc_pkg::MODE_DLA_BIT];

	// Accumulation decision per mode and class.
	logic in_block;
	logic do_acc;
	logic term_hit;
	logic second_hit;
	logic bisync;
	assign bisync   = acc_mode == bcgc_pkg::ACC_NORMAL || acc_mode == bcgc_pkg::ACC_TRANSP;
	assign in_block = bisync ? (acc_state != bcgc_pkg::BCGC_STOP) :
	                  (acc_mode == bcgc_pkg::ACC_AUTO) ? 1'b1 : single_arm;
	always_comb begin
		do_acc = 1'b0;
		if (use_cmp && in_block && poly != bcgc_pkg::POLY_NONE) begin
			case (acc_mode)
				bcgc_pkg::ACC_NORMAL: do_acc = (cls != bcgc_pkg::CLASS_SYNC) || acc_state == bcgc_pkg::BCGC_TAIL;
				bcgc_pkg::ACC_TRANSP: do_acc = acc_state == bcgc_pkg::BCGC_TAIL
				                       || !(esc_odd && cls == bcgc_pkg::CLASS_SYNC)
				                       && !(is_esc && !esc_odd);
				default:              do_acc = 1'b1;
			endcase
		end
	end
	assign term_hit   = do_acc && acc_state != bcgc_pkg::BCGC_TAIL && cls == bcgc_pkg::CLASS_TERM
	                    && (acc_mode != bcgc_pkg::ACC_TRANSP || esc_odd);
	assign second_hit = do_acc && acc_state != bcgc_pkg::BCGC_TAIL && cls == bcgc_pkg::CLASS_SECOND
	                    && esc_odd && acc_mode != bcgc_pkg::ACC_TRANSP;

	// ****************************************************************
	// Check remainder update
	// ****************************************************************
	logic [15:0] crc_in;
	logic [15:0] crc16_next;
	logic [11:0] crc12_next;
	logic [7:0]  next_hi;
	logic [7:0]  next_lo;
	always_comb begin
		crc16_next = {check_hi, check_lo};
		crc12_next = {check_hi[5:0], check_lo[5:0]};
		crc_in     = 16'h0000;
		for (int i = 0; i < 8; i++) begin
			if (crc16_next[15] ^ par_char[i])
				crc16_next = {crc16_next[14:0], 1'b0} ^ bcgc_pkg::CRC16_POLY;
			else
				crc16_next = {crc16_next[14:0], 1'b0};
		end
		for (int i = 0; i < 6; i++) begin
			if (crc12_next[11] ^ data_in[i])
				crc12_next = {crc12_next[10:0], 1'b0} ^ bcgc_pkg::CRC12_POLY;
			else
				crc12_next = {crc12_next[10:0], 1'b0};
		end
		case (poly)
			bcgc_pkg::POLY_CRC16: crc_in = crc16_next;
			bcgc_pkg::POLY_CRC12: crc_in = {2'h0, crc12_next[11:6], 2'h0, crc12_next[5:0]};
			bcgc_pkg::POLY_LRC8: begin
				crc_in[14:8] = check_hi[6:0] ^ data_in[6:0];
				crc_in[15]   = bcgc_parity(crc_in[14:8], par_even);
				crc_in[7:0]  = check_lo;
			end
			default:              crc_in = {check_hi, check_lo};
		endcase
		next_hi = crc_in[15:8];
		next_lo = crc_in[7:0];
	end

	// Remainder error test on the freshly accumulated value.
	logic rem_bad;
	assign rem_bad = (poly == bcgc_pkg::POLY_LRC8) ? (next_hi[6:0] != 7'h00) : ({next_hi, next_lo} != 16'h0000);

	// Command effects.
	logic cmd_wr;
	logic clear_cmd;
	logic mreset;
	logic mode_wr;
	logic check_wr;
	assign cmd_wr    = chk_wr && addr == bcgc_pkg::ADDR_CMD;
	assign clear_cmd = cmd_wr && data_in[1:0] == bcgc_pkg::CMD_CLEAR;
	assign mreset    = srst || (cmd_wr && data_in[1:0] == bcgc_pkg::CMD_MRESET);
	assign mode_wr   = chk_wr && addr == bcgc_pkg::ADDR_MODE;
	assign check_wr  = chk_wr && addr == bcgc_pkg::ADDR_CHECK;

	// ****************************************************************
	// Registers
	// ****************************************************************
	// Mode and command registers; one-time command bits are not kept.
	always_ff @(posedge clk) begin
		if (mreset) begin
			operating_mode <= bcgc_pkg::MODE_RESET;
			command        <= bcgc_pkg::CMD_RESET;
		end else begin
			if (mode_wr)
				operating_mode <= data_in;
			if (cmd_wr)
				command <= {data_in[7:2], 2'h0};
		end
	end

	// Class array is written while no polynomial is selected.
	always_ff @(posedge clk) begin
		if (mreset) begin
			for (int i = 0; i < 128; i++)
				class_array[i] <= bcgc_pkg::CLASS_NORMAL;
		end else if (chk_wr && addr == bcgc_pkg::ADDR_CLASS && poly == bcgc_pkg::POLY_NONE)
			class_array[data_in[6:0]] <= command[3:2];
	end

	// Character register keeps parity regenerated in its MSB while parity is enabled.
	always_ff @(posedge clk) begin
		if (srst)
			char_reg <= 8'h00;
		else if (load)
			char_reg <= par_char;
	end

	// Check registers and their shared load pointer.
	always_ff @(posedge clk) begin
		if (mreset || clear_cmd) begin
			check_hi  <= 8'h00;
			check_lo  <= 8'h00;
			check_ptr <= 1'b0;
		end else if (check_wr) begin
			if (check_ptr)
				check_lo <= data_in;
			else
				check_hi <= data_in;
			check_ptr <= ~check_ptr;
		end else if (load && do_acc) begin
			check_hi <= next_hi;
			check_lo <= next_lo;
		end
	end

	// Block state: stop after terminator, on receive only after the trailing check characters.
	always_ff @(posedge clk) begin
		if (mreset || clear_cmd || check_wr || mode_wr) begin
			acc_state <= bcgc_pkg::BCGC_RUN;
			tail_cnt  <= 2'h0;
		end else if (cmd_wr && data_in[1:0] == bcgc_pkg::CMD_START) begin
			acc_state <= bcgc_pkg::BCGC_RUN;
		end else if (load && do_acc && bisync) begin
			case (acc_state)
				bcgc_pkg::BCGC_RUN: begin
					if (term_hit && dir_tx)
						acc_state <= bcgc_pkg::BCGC_STOP;
					else if (term_hit) begin
						acc_state <= bcgc_pkg::BCGC_TAIL;
						tail_cnt  <= (poly == bcgc_pkg::POLY_LRC8) ? 2'h1 : 2'h2;
					end
				end
				bcgc_pkg::BCGC_TAIL: begin
					tail_cnt <= tail_cnt - 2'h1;
					if (tail_cnt == 2'h1)
						acc_state <= bcgc_pkg::BCGC_STOP;
				end
				default: acc_state <= bcgc_pkg::BCGC_STOP;
			endcase
		end
	end

	// Escape parity tracker and single-mode arm; start does not cancel an escape.
	always_ff @(posedge clk) begin
		if (mreset || clear_cmd || check_wr) begin
			esc_odd    <= 1'b0;
			single_arm <= 1'b0;
		end else begin
			if (cmd_wr && data_in[1:0] == bcgc_pkg::CMD_START && acc_mode == bcgc_pkg::ACC_SINGLE)
				single_arm <= 1'b1;
			else if (load)
				single_arm <= 1'b0;
			if (load && use_cmp && acc_state != bcgc_pkg::BCGC_TAIL)
				esc_odd <= is_esc ? ~esc_odd : 1'b0;
		end
	end

	// Status flags: a new event wins over the clearing status read.
	logic status_rd;
	logic chk_done;
	assign status_rd = chk_rd && addr == bcgc_pkg::ADDR_STATUS;
	assign chk_done  = load && do_acc && !dir_tx
	                   && (!bisync || (acc_state == bcgc_pkg::BCGC_TAIL && tail_cnt == 2'h1));
	always_ff @(posedge clk) begin
		if (mreset || clear_cmd || check_wr) begin
			flags <= '0;
		end else begin
			if (chk_done)
				flags.check_error <= rem_bad;
			else if (status_rd)
				flags.check_error <= 1'b0;
			flags.parity_error <= (load && par_bad) || (flags.parity_error && !status_rd);
			flags.terminator   <= term_hit && load || (flags.terminator && !status_rd);
			flags.escape_pair  <= second_hit && load || (flags.escape_pair && !status_rd);
		end
	end

	// ****************************************************************
	// Read data and interrupt
	// ****************************************************************
	// Read data is registered from the selected register.
	always_ff @(posedge clk) begin
		if (srst) begin
			data_out <= 8'h00;
			data_oe  <= 1'b0;
		end else begin
			data_oe <= chk_rd;
			// Only a checker read refreshes the data, so it stands until the next read.
			if (chk_rd) begin
				case (addr)
					bcgc_pkg::ADDR_CHAR:   data_out <= char_reg;
					bcgc_pkg::ADDR_STATUS: data_out <= {command[7:4], flags.escape_pair, flags.terminator,
					                                    flags.parity_error, flags.check_error};
					bcgc_pkg::ADDR_CMD:    data_out <= operating_mode;
					default:               data_out <= check_ptr ? check_lo : check_hi;
				endcase
			end
		end
	end

	// Open-drain interrupt is driven low while any enabled flag is set.
	always_ff @(posedge clk) begin
		if (srst)
			irq_n_oe <= 1'b0;
		else
			irq_n_oe <= |(command[7:4] & {flags.escape_pair, flags.terminator,
			                              flags.parity_error, flags.check_error});
	end
	assign irq_n_out = 1'b0;

endmodule : bcgc_core
